// ===== mrc_debounce.sv
// Counts slow-oscillator ticks while a reset request stands.
// Assumes tick is a one-cycle pulse per slow period; fire holds while req stays high.
`timescale 1ns/1ps
module mrc_debounce (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic tick,
  output logic fire
);

  logic [1:0] cnt_ff;

  // Three ticks give two to three slow periods, whatever the phase of the request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 2'h0;
    end else if (!req) begin
      cnt_ff <= 2'h0;
    end else if (tick && cnt_ff != mrc_pkg::DEB_TICKS) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  assign fire = req && (cnt_ff == mrc_pkg::DEB_TICKS);

endmodule

// ===== mrc_pkg.sv
// Constants, types and register layout shared by the reset controller files.
// Assumes a single 20 MHz system clock; all times are turned into cycle counts here.
package mrc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam real EXT_DELAY_MS = 16.7;
  localparam real LONG_DELAY_MS = 50.0;
  localparam int EXT_DELAY_CYC = int'(EXT_DELAY_MS * CLK_HZ / 1000.0);
  localparam int LONG_DELAY_CYC = int'(LONG_DELAY_MS * CLK_HZ / 1000.0);
  localparam int BO_QUAL_CYC = 20;
  localparam int CNT_W = 20;
  localparam logic [1:0] DEB_TICKS = 2'h3;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [7:0] ROLE_PORT = 8'h55;
  localparam logic [7:0] ROLE_CLEAR = 8'haa;
  localparam logic [7:0] ROLE_RST = 8'h55;
  localparam logic [4:0] WCTL_DIS = 5'h15;
  localparam logic [4:0] WCTL_EN = 5'h0a;

  // ****************************************************************
  // Register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [4:0] OFS_ROLE = 5'h00;
  localparam logic [4:0] OFS_RFLAGS = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_IRQ_ST = 5'h0c;
  localparam logic [4:0] OFS_IRQ_MSK = 5'h10;
  localparam int RF_KEEP_BIT = 7;
  localparam int RF_CFG_BIT = 3;
  localparam int RF_BO_BIT = 2;
  localparam int RF_WCTL_BIT = 0;
  localparam int ST_EXPIRY_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 5'h00;

  typedef enum logic [1:0] {MRC_RUN, MRC_HOLD, MRC_DELAY} mrc_state_e;

  typedef struct packed {
    logic idle_keep;
    logic cfg_fault;
    logic brownout;
    logic wctl_fault;
  } mrc_rflags_s;

  localparam mrc_rflags_s RFLAGS_RST = '{idle_keep: 1'b0, cfg_fault: 1'b0,
                                         brownout: 1'b0, wctl_fault: 1'b0};

  typedef struct packed {
    logic wdog_tout;
    logic wctl;
    logic cfg;
    logic bo;
    logic ext;
  } mrc_events_s;

endpackage

// ===== mrc_reset_ctrl.sv
// Reset controller: merges pin, role-code, brownout and watchdog resets.
// Assumes an Avalon-MM master on CLK and watchdog/mode signals from CLK logic.
//
// Overview of operation
// - Clear pin low in clear role holds the device in reset; release restarts at zero.
// - After the clear pin rises, wait the short start-up delay before running.
// - Role code 55 selects port, AA clear pin; others reset after debounce.
// - Every reset restores the role code except a watchdog warm reset.
// - Role-code fault flag is set by hardware, only cleared by software or power-on.
// - Brownout acts in run modes after qualification, resetting after slow-clock debounce.
// - Brownout reset is disabled whenever sleep or idle mode is active.
// - Brownout flag set by brownout reset; writes can only clear it.
// - Watchdog code fault flag set by code fault; only software or power-on clears it.
// - Bit 7 of reset flags keeps system clock running in idle.
// - Reset flags bits 6 to 4 and bit 1 read as zero.
// - Brownout reset applies the long start-up delay.
// - Watchdog time-out in run mode acts like brownout and sets expiry flag.
// - Watchdog time-out in sleep or idle clears only PC and stack, sets expiry and power-down.
// - Power-on clears expiry and power-down; brownout keeps; watchdog sets as listed.
// - Full reset disables interrupts, restarts watchdog, stops timers, inputs ports.
// - Watchdog codes 15 and 0A are valid; others reset after debounce.
`timescale 1ns/1ps
module mrc_reset_ctrl #(
  parameter int EXT_DELAY_CYC = mrc_pkg::EXT_DELAY_CYC,
  parameter int LONG_DELAY_CYC = mrc_pkg::LONG_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_CLEAR_PIN_N,
  input wire logic LOW_SUPPLY,
  input wire logic SLOW_OSC,
  input wire logic [4:0] WDOG_CTRL_CODE,
  input wire logic WDOG_TIMEOUT,
  input wire logic SLEEP_MODE,
  input wire logic IDLE_MODE,
  output logic SYS_RESET,
  output logic PC_SP_CLEAR,
  output logic PIN_IS_CLEAR,
  output logic IDLE_SYSCLK_KEEP,
  output logic WDOG_EXPIRY_FLAG,
  output logic POWERDOWN_FLAG,
  output logic IRQ
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] ofs);
    reg_hit = (addr[4:2] == ofs[4:2]);
  endfunction

  function automatic logic [7:0] rflags_byte(input mrc_pkg::mrc_rflags_s s);
    logic [7:0] b;
    b = 8'h00;
    b[mrc_pkg::RF_KEEP_BIT] = s.idle_keep;
    b[mrc_pkg::RF_CFG_BIT] = s.cfg_fault;
    b[mrc_pkg::RF_BO_BIT] = s.brownout;
    b[mrc_pkg::RF_WCTL_BIT] = s.wctl_fault;
    rflags_byte = b;
  endfunction

  // ****************************************************************
  // Pin inputs and slow tick
  // ****************************************************************
  logic ext_n_q;
  logic low_q;
  logic slow_q;
  logic slow_prev_ff;
  logic slow_tick;

  mrc_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({EXT_CLEAR_PIN_N, LOW_SUPPLY, SLOW_OSC}),
    .q({ext_n_q, low_q, slow_q})
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slow_prev_ff <= 1'b0;
    end else begin
      slow_prev_ff <= slow_q;
    end
  end

  assign slow_tick = slow_q && !slow_prev_ff;

  // ****************************************************************
  // Reset requests
  // ****************************************************************
  logic [7:0] role_ff;
  logic ext_active;
  logic role_bad;
  logic wctl_bad;
  logic low_power_mode;
  logic bo_req;
  logic [7:0] bo_cnt_ff;
  logic cfg_fire;
  logic bo_fire;
  logic wctl_fire;
  logic any_req;
  logic [2:0] deb_req;
  logic [2:0] deb_fire;

  assign low_power_mode = SLEEP_MODE || IDLE_MODE;
  assign ext_active = (role_ff == mrc_pkg::ROLE_CLEAR) && !ext_n_q;
  assign role_bad = (role_ff != mrc_pkg::ROLE_PORT) && (role_ff != mrc_pkg::ROLE_CLEAR);
  assign wctl_bad = (WDOG_CTRL_CODE != mrc_pkg::WCTL_DIS) &&
                    (WDOG_CTRL_CODE != mrc_pkg::WCTL_EN);

  // The low level must outlast the qualification time; a shorter dip is ignored.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bo_cnt_ff <= 8'h00;
    end else if (!low_q || low_power_mode) begin
      bo_cnt_ff <= 8'h00;
    end else if (bo_cnt_ff != 8'(mrc_pkg::BO_QUAL_CYC)) begin
      bo_cnt_ff <= bo_cnt_ff + 8'h01;
    end
  end

  assign bo_req = (bo_cnt_ff == 8'(mrc_pkg::BO_QUAL_CYC)) && !low_power_mode;
  assign deb_req = {wctl_bad, bo_req, role_bad};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
      mrc_debounce u_deb (
        .clk(CLK),
        .rst_n(RST_N),
        .req(deb_req[gi]),
        .tick(slow_tick),
        .fire(deb_fire[gi])
      );
    end
  endgenerate

  assign cfg_fire = deb_fire[0];
  assign bo_fire = deb_fire[1];
  assign wctl_fire = deb_fire[2];
  assign any_req = ext_active || cfg_fire || bo_fire || wctl_fire;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  mrc_pkg::mrc_state_e state_ff;
  mrc_pkg::mrc_state_e nxt_state;
  logic [mrc_pkg::CNT_W-1:0] cnt_ff;
  logic [mrc_pkg::CNT_W-1:0] nxt_cnt;
  logic long_ff;
  logic nxt_long;
  logic wd_normal;
  logic wd_warm;
  logic full_start;
  logic delay_end;
  logic role_restore;

  assign wd_normal = WDOG_TIMEOUT && !low_power_mode && (state_ff == mrc_pkg::MRC_RUN);
  assign wd_warm = WDOG_TIMEOUT && low_power_mode && (state_ff == mrc_pkg::MRC_RUN);
  assign full_start = (state_ff == mrc_pkg::MRC_RUN) && (any_req || wd_normal);
  assign delay_end = (state_ff == mrc_pkg::MRC_DELAY) && !any_req && (cnt_ff == '0);
  // Restoring the role while the clear pin holds would cancel that very request.
  assign role_restore = delay_end || (full_start && !ext_active);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_long = long_ff;
    if (cfg_fire || bo_fire || wctl_fire) begin
      nxt_long = 1'b1;
    end else if (ext_active) begin
      nxt_long = 1'b0;
    end
    case (state_ff)
      mrc_pkg::MRC_RUN: begin
        if (any_req) begin
          nxt_state = mrc_pkg::MRC_HOLD;
        end else if (wd_normal) begin
          nxt_state = mrc_pkg::MRC_DELAY;
          nxt_long = 1'b1;
          nxt_cnt = mrc_pkg::CNT_W'(LONG_DELAY_CYC - 1);
        end
      end
      mrc_pkg::MRC_HOLD: begin
        if (!any_req) begin
          nxt_state = mrc_pkg::MRC_DELAY;
          nxt_cnt = long_ff ? mrc_pkg::CNT_W'(LONG_DELAY_CYC - 1)
                            : mrc_pkg::CNT_W'(EXT_DELAY_CYC - 1);
        end
      end
      mrc_pkg::MRC_DELAY: begin
        if (any_req) begin
          nxt_state = mrc_pkg::MRC_HOLD;
        end else if (cnt_ff == '0) begin
          nxt_state = mrc_pkg::MRC_RUN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = mrc_pkg::MRC_HOLD;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= mrc_pkg::MRC_HOLD;
      cnt_ff <= '0;
      long_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      long_ff <= nxt_long;
    end
  end

  // The rest of the chip clears interrupts, watchdog, timers and ports on this level.
  assign SYS_RESET = (state_ff != mrc_pkg::MRC_RUN);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PC_SP_CLEAR <= 1'b0;
    end else begin
      PC_SP_CLEAR <= wd_warm;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic ack_ff;
  logic wr_go;
  logic wr_lane;
  logic [7:0] wd;
  mrc_pkg::mrc_rflags_s rflags_ff;
  logic [1:0] status_ff;
  logic [mrc_pkg::IRQ_W-1:0] irq_st_ff;
  logic [mrc_pkg::IRQ_W-1:0] irq_msk_ff;
  logic [3:0] req_prev_ff;
  mrc_pkg::mrc_events_s ev;
  logic [7:0] rmux;

  // One wait state: the answer is always ready on the second cycle of a request.
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_ff;
  assign wr_go = AVS_WRITE && ack_ff;
  assign wr_lane = wr_go && AVS_BYTEENABLE[0];
  assign wd = AVS_WRITEDATA[7:0];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (AVS_READ || AVS_WRITE) && !ack_ff;
    end
  end

  always_comb begin
    rmux = 8'h00;
    if (reg_hit(AVS_ADDRESS, mrc_pkg::OFS_ROLE)) begin
      rmux = role_ff;
    end else if (reg_hit(AVS_ADDRESS, mrc_pkg::OFS_RFLAGS)) begin
      rmux = rflags_byte(rflags_ff);
    end else if (reg_hit(AVS_ADDRESS, mrc_pkg::OFS_STATUS)) begin
      rmux = {6'h00, status_ff};
    end else if (reg_hit(AVS_ADDRESS, mrc_pkg::OFS_IRQ_ST)) begin
      rmux = {3'h0, irq_st_ff};
    end else if (reg_hit(AVS_ADDRESS, mrc_pkg::OFS_IRQ_MSK)) begin
      rmux = {3'h0, irq_msk_ff};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack_ff) begin
      AVS_READDATA <= {24'h00_0000, rmux};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      role_ff <= mrc_pkg::ROLE_RST;
    end else if (role_restore) begin
      role_ff <= mrc_pkg::ROLE_RST;
    end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_ROLE)) begin
      role_ff <= wd;
    end
  end

  // Fault flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rflags_ff <= mrc_pkg::RFLAGS_RST;
    end else begin
      if (full_start) begin
        rflags_ff.idle_keep <= 1'b0;
      end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_RFLAGS)) begin
        rflags_ff.idle_keep <= wd[mrc_pkg::RF_KEEP_BIT];
      end
      if (cfg_fire) begin
        rflags_ff.cfg_fault <= 1'b1;
      end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_RFLAGS)) begin
        rflags_ff.cfg_fault <= rflags_ff.cfg_fault && wd[mrc_pkg::RF_CFG_BIT];
      end
      if (bo_fire) begin
        rflags_ff.brownout <= 1'b1;
      end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_RFLAGS)) begin
        rflags_ff.brownout <= rflags_ff.brownout && wd[mrc_pkg::RF_BO_BIT];
      end
      if (wctl_fire) begin
        rflags_ff.wctl_fault <= 1'b1;
      end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_RFLAGS)) begin
        rflags_ff.wctl_fault <= rflags_ff.wctl_fault && wd[mrc_pkg::RF_WCTL_BIT];
      end
    end
  end

  // Expiry and power-down flags; only power-on clears them besides a software write of one.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_ff <= 2'h0;
    end else begin
      if (wd_normal || wd_warm) begin
        status_ff[mrc_pkg::ST_EXPIRY_BIT] <= 1'b1;
      end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_STATUS) &&
                   wd[mrc_pkg::ST_EXPIRY_BIT]) begin
        status_ff[mrc_pkg::ST_EXPIRY_BIT] <= 1'b0;
      end
      if (wd_warm) begin
        status_ff[mrc_pkg::ST_PD_BIT] <= 1'b1;
      end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_STATUS) &&
                   wd[mrc_pkg::ST_PD_BIT]) begin
        status_ff[mrc_pkg::ST_PD_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_prev_ff <= 4'h0;
    end else begin
      req_prev_ff <= {wctl_fire, cfg_fire, bo_fire, ext_active};
    end
  end

  assign ev = '{wdog_tout: wd_normal || wd_warm,
                wctl: wctl_fire && !req_prev_ff[3],
                cfg: cfg_fire && !req_prev_ff[2],
                bo: bo_fire && !req_prev_ff[1],
                ext: ext_active && !req_prev_ff[0]};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_st_ff <= '0;
    end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_IRQ_ST)) begin
      irq_st_ff <= (irq_st_ff & ~wd[mrc_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_st_ff <= irq_st_ff | ev;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_msk_ff <= mrc_pkg::IRQ_MSK_RST;
    end else if (wr_lane && reg_hit(AVS_ADDRESS, mrc_pkg::OFS_IRQ_MSK)) begin
      irq_msk_ff <= wd[mrc_pkg::IRQ_W-1:0];
    end
  end

  assign IRQ = |(irq_st_ff & irq_msk_ff);
  assign PIN_IS_CLEAR = (role_ff == mrc_pkg::ROLE_CLEAR);
  assign IDLE_SYSCLK_KEEP = rflags_ff.idle_keep;
  assign WDOG_EXPIRY_FLAG = status_ff[mrc_pkg::ST_EXPIRY_BIT];
  assign POWERDOWN_FLAG = status_ff[mrc_pkg::ST_PD_BIT];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  pin_hold_a: assert property (ext_active |=> SYS_RESET)
    else $error("clear pin low did not hold reset");
  short_delay_a: assert property (state_ff == mrc_pkg::MRC_HOLD && !any_req && !long_ff
    |=> cnt_ff == mrc_pkg::CNT_W'(EXT_DELAY_CYC - 1))
    else $error("short start-up delay not loaded");
  role_fault_a: assert property (cfg_fire |=> SYS_RESET && rflags_ff.cfg_fault)
    else $error("bad role code did not reset");
  role_restore_a: assert property (delay_end |=> role_ff == mrc_pkg::ROLE_RST)
    else $error("role code not restored after reset");
  bo_sleep_a: assert property (low_power_mode |-> !bo_req ##1 bo_cnt_ff == 8'h00)
    else $error("brownout active in low power mode");
  bo_flag_a: assert property (bo_fire |=> rflags_ff.brownout && SYS_RESET)
    else $error("brownout flag not set");
  wctl_flag_a: assert property (wctl_fire |=> rflags_ff.wctl_fault ##1 SYS_RESET)
    else $error("watchdog code fault flag not set");
  unimpl_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST &&
    reg_hit(AVS_ADDRESS, mrc_pkg::OFS_RFLAGS) |-> AVS_READDATA[6:4] == 3'h0 &&
    !AVS_READDATA[1])
    else $error("unimplemented flag bits read non-zero");
  long_delay_a: assert property (wd_normal && !any_req
    |=> cnt_ff == mrc_pkg::CNT_W'(LONG_DELAY_CYC - 1) && WDOG_EXPIRY_FLAG)
    else $error("watchdog reset without long delay or expiry");
  warm_reset_a: assert property (wd_warm && !any_req && !wr_go |=> PC_SP_CLEAR && !SYS_RESET
    && WDOG_EXPIRY_FLAG && POWERDOWN_FLAG && $stable(role_ff) ##1 !PC_SP_CLEAR)
    else $error("warm watchdog reset wrong");
  run_after_delay_a: assert property (delay_end |=> !SYS_RESET)
    else $error("delay end did not release reset");

  ext_reset_c: cover property (ext_active ##[1:20] state_ff == mrc_pkg::MRC_DELAY);
  warm_reset_c: cover property (wd_warm);
  bo_reset_c: cover property (bo_fire);
  irq_c: cover property ($rose(IRQ));

endmodule

// ===== mrc_reset_ctrl_tb.sv
// Self-checking bench for the reset controller.
// Assumes shortened start-up delays and a free-running slow oscillator model.
`timescale 1ns/1ps
module mrc_reset_ctrl_tb;
  localparam int EXT_D = 20;
  localparam int LONG_D = 40;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'h1;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, EXT_CLEAR_PIN_N, LOW_SUPPLY, SLOW_OSC;
  logic [4:0] WDOG_CTRL_CODE = 5'h0a;
  logic [4:0] code;
  logic WDOG_TIMEOUT = 1'b0;
  logic SLEEP_MODE = 1'b0;
  logic IDLE_MODE = 1'b0;
  logic pull_low = 1'b0;
  logic sag = 1'b0;
  logic SYS_RESET, PC_SP_CLEAR, PIN_IS_CLEAR, IDLE_SYSCLK_KEEP;
  logic WDOG_EXPIRY_FLAG, POWERDOWN_FLAG, IRQ;
  int error_cnt = 0;
  int n_checks = 0;
  int n = 0;
  int seed = 65;
  logic [31:0] exp_q[$];

  always #25 CLK = ~CLK;

  mrc_reset_ctrl #(.EXT_DELAY_CYC(EXT_D), .LONG_DELAY_CYC(LONG_D)) mrc_reset_ctrl_inst (
    .CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXT_CLEAR_PIN_N(EXT_CLEAR_PIN_N), .LOW_SUPPLY(LOW_SUPPLY), .SLOW_OSC(SLOW_OSC),
    .WDOG_CTRL_CODE(WDOG_CTRL_CODE), .WDOG_TIMEOUT(WDOG_TIMEOUT), .SLEEP_MODE(SLEEP_MODE),
    .IDLE_MODE(IDLE_MODE), .SYS_RESET(SYS_RESET), .PC_SP_CLEAR(PC_SP_CLEAR),
    .PIN_IS_CLEAR(PIN_IS_CLEAR), .IDLE_SYSCLK_KEEP(IDLE_SYSCLK_KEEP),
    .WDOG_EXPIRY_FLAG(WDOG_EXPIRY_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG), .IRQ(IRQ));

  mrc_supply_net mrc_supply_net_inst (.clk(CLK), .pull_low(pull_low), .sag(sag),
    .clear_pin_n(EXT_CLEAR_PIN_N), .low_supply(LOW_SUPPLY), .slow_osc(SLOW_OSC));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // For a read, d is the expected data; waitrequest is sampled mid-cycle, where it has settled.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    if (!wr) exp_q.push_back(d);
    @(negedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) @(negedge CLK);
    @(posedge CLK);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task wait_lvl(input logic lvl, input int mx);
    n = 0;
    @(negedge CLK);
    while (SYS_RESET !== lvl && n < mx) begin
      @(negedge CLK);
      n++;
    end
  endtask

  task tout;
    @(posedge CLK);
    WDOG_TIMEOUT <= 1'b1;
    @(posedge CLK);
    WDOG_TIMEOUT <= 1'b0;
  endtask

  always @(negedge CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      chk(AVS_READDATA, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    results();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    chk(SYS_RESET, 1'b1);
    wait_lvl(1'b0, 200);
    chk(n inside {[LONG_D-2:LONG_D+3]}, 1'b1);
    bus(0, 5'h00, 32'h55);
    bus(0, 5'h04, 32'h00);
    bus(0, 5'h08, 32'h00);
    bus(0, 5'h14, 32'h00);
    bus(1, 5'h04, 32'hff);
    bus(0, 5'h04, 32'h80);
    chk(IDLE_SYSCLK_KEEP, 1'b1);
    AVS_BYTEENABLE <= 4'h0;
    bus(1, 5'h04, $random(seed));
    AVS_BYTEENABLE <= 4'h1;
    bus(0, 5'h04, 32'h80);
    $display("registers test done");
    bus(1, 5'h00, 32'h12);
    wait_lvl(1'b1, 200);
    chk(SYS_RESET, 1'b1);
    wait_lvl(1'b0, 200);
    chk(n inside {[LONG_D:LONG_D+6]}, 1'b1);
    bus(0, 5'h00, 32'h55);
    bus(0, 5'h04, 32'h08);
    bus(1, 5'h04, 32'h00);
    bus(0, 5'h04, 32'h00);
    $display("role fault test done");
    bus(1, 5'h00, 32'haa);
    @(negedge CLK);
    chk(PIN_IS_CLEAR, 1'b1);
    pull_low <= 1'b1;
    wait_lvl(1'b1, 10);
    repeat (30) @(posedge CLK);
    chk(SYS_RESET, 1'b1);
    pull_low <= 1'b0;
    wait_lvl(1'b0, 200);
    chk(n inside {[EXT_D:EXT_D+6]}, 1'b1);
    bus(0, 5'h00, 32'h55);
    $display("clear pin test done");
    SLEEP_MODE <= 1'b1;
    sag <= 1'b1;
    repeat (100) @(posedge CLK);
    chk(SYS_RESET, 1'b0);
    sag <= 1'b0;
    SLEEP_MODE <= 1'b0;
    repeat (5) @(posedge CLK);
    sag <= 1'b1;
    repeat (10) @(posedge CLK);
    sag <= 1'b0;
    repeat (60) @(posedge CLK);
    chk(SYS_RESET, 1'b0);
    sag <= 1'b1;
    wait_lvl(1'b1, 200);
    chk(SYS_RESET, 1'b1);
    sag <= 1'b0;
    wait_lvl(1'b0, 200);
    chk(n inside {[LONG_D:LONG_D+6]}, 1'b1);
    bus(0, 5'h04, 32'h04);
    bus(0, 5'h08, 32'h00);
    bus(1, 5'h04, 32'h00);
    $display("brownout test done");
    bus(1, 5'h10, 32'h10);
    bus(1, 5'h00, 32'haa);
    IDLE_MODE <= 1'b1;
    tout();
    @(negedge CLK);
    chk(PC_SP_CLEAR, 1'b1);
    chk(POWERDOWN_FLAG, 1'b1);
    @(negedge CLK);
    chk(PC_SP_CLEAR, 1'b0);
    chk(SYS_RESET, 1'b0);
    chk(IRQ, 1'b1);
    bus(0, 5'h08, 32'h03);
    bus(0, 5'h00, 32'haa);
    bus(0, 5'h0c, 32'h17);
    bus(1, 5'h0c, 32'h10);
    bus(0, 5'h0c, 32'h07);
    chk(IRQ, 1'b0);
    IDLE_MODE <= 1'b0;
    tout();
    wait_lvl(1'b1, 5);
    chk(SYS_RESET, 1'b1);
    wait_lvl(1'b0, 200);
    chk(n inside {[LONG_D-2:LONG_D+3]}, 1'b1);
    bus(0, 5'h08, 32'h03);
    bus(0, 5'h00, 32'h55);
    bus(1, 5'h08, 32'h01);
    @(negedge CLK);
    chk(WDOG_EXPIRY_FLAG, 1'b0);
    chk(POWERDOWN_FLAG, 1'b1);
    @(posedge CLK);
    RST_N <= 1'b0;
    @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    chk(POWERDOWN_FLAG, 1'b0);
    wait_lvl(1'b0, 200);
    chk(n inside {[LONG_D-2:LONG_D+3]}, 1'b1);
    $display("watchdog time-out test done");
    WDOG_CTRL_CODE <= 5'h15;
    repeat (50) @(posedge CLK);
    chk(SYS_RESET, 1'b0);
    do code = 5'($random(seed)); while (code == 5'h15 || code == 5'h0a);
    WDOG_CTRL_CODE <= code;
    wait_lvl(1'b1, 200);
    chk(SYS_RESET, 1'b1);
    WDOG_CTRL_CODE <= 5'h0a;
    wait_lvl(1'b0, 200);
    chk(n inside {[LONG_D:LONG_D+6]}, 1'b1);
    bus(0, 5'h04, 32'h01);
    bus(1, 5'h04, 32'h00);
    bus(0, 5'h04, 32'h00);
    $display("watchdog code test done");
    results();
  end
endmodule

// ===== mrc_supply_net.sv
// Model of the external reset network, supply monitor and slow oscillator.
// Assumes the bench commands pin pull-down and supply sag as levels.
`timescale 1ns/1ps
module mrc_supply_net (
  input wire logic clk,
  input wire logic pull_low,
  input wire logic sag,
  output logic clear_pin_n,
  output logic low_supply,
  output logic slow_osc
);
  logic [2:0] div_ff = 3'h0;

  // The pin has a pull-up, so a released pin reads high.
  assign clear_pin_n = !pull_low;
  assign low_supply = sag;

  // The slow oscillator runs free, one eighth of clk, so debounce spans whole slow periods.
  always_ff @(posedge clk) begin
    div_ff <= div_ff + 3'h1;
  end
  assign slow_osc = div_ff[2];
endmodule

// ===== mrc_sync.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes the inputs are slow levels; a pulse shorter than one clock may be missed.
`timescale 1ns/1ps
module mrc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule
